// ### logic/jtg_pkg.sv
// shared types and constants for the boundary-scan test access port
package jtg_pkg;

    // boundary-scan chain layout, cell 0 is nearest the serial output
    localparam int BSR_LEN = 365;
    localparam int CELL_RX_FAST_LINK_DATA_CLOCK = 364;
    localparam int CELL_RX_FAST_LINK_FRAME_PULSE_N = 363;
    localparam int CELL_RX_FAST_LINK_FRAME_CLOCK = 362;
    localparam int OUT_BASE = 0;
    localparam int NUM_OUT = 8;
    localparam int IO_BASE = 8;
    localparam int NUM_IO = 8;
    localparam int OEN_CELL = 16;
    localparam int LOGIC0_LO = 17;
    localparam int LOGIC0_HI = 281;
    localparam int LOGIC1_LO = 282;
    localparam int LOGIC1_HI = 285;
    localparam int UNCONN_LO = 286;
    localparam int UNCONN_HI = 287;
    localparam int IN_BASE = 288;
    localparam int NUM_IN = 77;

    // identification code, also loaded into the top input cells
    localparam int ID_W = 32;
    localparam int ID_BASE = 333;

    // instruction register
    localparam int IR_W = 3;
    localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] OP_SAMPLE = 3'h1;
    localparam logic [IR_W-1:0] OP_IDCODE = 3'h2;
    localparam logic [IR_W-1:0] OP_STCTEST = 3'h3;
    localparam logic [IR_W-1:0] OP_INTEST = 3'h4;
    localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jtg_tap_state_t;

    typedef enum logic [2:0] {
        CK_IN, CK_OUT, CK_IO, CK_OEN, CK_LOGIC0, CK_LOGIC1, CK_UNCONN
    } jtg_cell_kind_t;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_ID, SEL_BSR
    } jtg_dr_sel_t;

    // test pins as sampled from the board
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jtg_tap_pins_t;

    // one-cycle data-register strobes
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
    } jtg_dr_ctl_t;

    function automatic jtg_cell_kind_t jtg_cell_kind(input int idx);
        if (idx >= IN_BASE) begin
            return CK_IN;
        end else if (idx >= UNCONN_LO) begin
            return CK_UNCONN;
        end else if (idx >= LOGIC1_LO) begin
            return CK_LOGIC1;
        end else if (idx >= LOGIC0_LO) begin
            return CK_LOGIC0;
        end else if (idx == OEN_CELL) begin
            return CK_OEN;
        end else if (idx >= IO_BASE) begin
            return CK_IO;
        end else begin
            return CK_OUT;
        end
    endfunction

endpackage

// ### logic/jtg_tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/1ps
module jtg_tap_fsm
    import jtg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sampled test clock edge and mode select
    input wire logic tck_rise_i,
    input wire logic tms_i,
    // controller state
    output jtg_tap_state_t state_o
);

    jtg_tap_state_t state_q;
    jtg_tap_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: state_d = tms_i ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms_i ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tms_i ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    // five high mode-select edges reach reset from any state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_RESET;
        end else if (tck_rise_i) begin
            state_q <= state_d;
        end
    end

    assign state_o = state_q;

endmodule

// ### logic/jtg_bsr.sv
// boundary-scan shift stages with their parallel output latches
`timescale 1ns/1ps
module jtg_bsr
    import jtg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // strobes and serial input
    input jtg_dr_ctl_t ctl_i,
    input wire logic tdi_i,
    // parallel capture values, one per cell
    input wire logic [BSR_LEN-1:0] cap_i,
    // serial output and latched pattern
    output logic serial_o,
    output logic [BSR_LEN-1:0] upd_o
);

    logic [BSR_LEN-1:0] shift_q;
    logic [BSR_LEN-1:0] upd_q;

    // the top cell takes the serial input, so it sits next to it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= '0;
        end else if (ctl_i.capture) begin
            shift_q <= cap_i;
        end else if (ctl_i.shift) begin
            shift_q <= {tdi_i, shift_q[BSR_LEN-1:1]};
        end
    end

    // the latches only move on update, so outputs hold during shifting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upd_q <= '0;
        end else if (ctl_i.update) begin
            upd_q <= shift_q;
        end
    end

    assign serial_o = shift_q[0];
    assign upd_o = upd_q;

endmodule

// ### logic/jtg_tap_top.sv
// boundary-scan test access port: pin sampling, registers and chain
//
// Overview of operation
// - fast-link data clock observer cell 364 is the stage next to tdi
// - an output-enable cell holding one tristates the pins it controls
// - tied cells observe a fixed zero or one
// - unbonded cells stay in chain; their capture equals their own output
// - data-register scan clock follows tck only in capture and shift data
// - active-low test reset forces the controller into reset
// - tck samples tdi and drives tdo
// - controller advances only on rising test clock edges
// - every state change depends only on the mode select input
// - controller state produces the load strobes for all registers
// - current instruction picks the operation and the data register
// - bypass gives exactly one stage between tdi and tdo
// - identification register reads out a fixed code serially
// - chain sits in series with all pins so inputs are sampled
// - patterns shifted into the chain can drive every output
// - five high mode-select clocks reach reset, which loads identify
// - shift states move registers one stage toward the lsb per edge
// - update-data loads output latches on the falling test clock
`timescale 1ns/1ps
module jtg_tap_top
    import jtg_pkg::*;
#(
    // identification code, value arbitrary
    parameter logic [ID_W-1:0] ID_CODE = 32'h0000_1001
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // test access pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    // scan clock handed to the cells
    output logic data_reg_scan_clock_o,
    // device pads
    input wire logic [NUM_IN-1:0] pad_in_i,
    output logic [NUM_OUT-1:0] out_pad_o,
    input wire logic [NUM_IO-1:0] io_pad_i,
    output logic [NUM_IO-1:0] io_pad_o,
    output logic [NUM_IO-1:0] io_pad_oe_n_o,
    // core side of the pads
    output logic [NUM_IN-1:0] core_in_o,
    input wire logic [NUM_OUT-1:0] core_out_i,
    input wire logic [NUM_IO-1:0] core_io_out_i,
    input wire logic core_io_oe_n_i,
    output logic [NUM_IO-1:0] core_io_in_o,
    // status
    output jtg_tap_state_t tap_state_o,
    output logic [IR_W-1:0] instr_o
);

    // ------------------------------------------------------------------
    // pin sampling: two stages, then an edge finder on the test clock
    // ------------------------------------------------------------------
    jtg_tap_pins_t pins_raw;
    jtg_tap_pins_t pins_meta_q;
    jtg_tap_pins_t pins_q;
    logic tck_prev_q;
    logic tck_rise;
    logic tck_fall;
    logic tap_rst;

    logic [NUM_IN-1:0] pad_in_meta_q;
    logic [NUM_IN-1:0] pad_in_q;
    logic [NUM_IO-1:0] io_pad_meta_q;
    logic [NUM_IO-1:0] io_pad_q;

    assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i,
                        trst_n: trst_n_i};

    // tms and tdi share the tck path length so they line up with its edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_meta_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0,
                             trst_n: 1'b0};
            pins_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
            tck_prev_q <= 1'b0;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q <= pins_meta_q;
            tck_prev_q <= pins_q.tck;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_in_meta_q <= '0;
            pad_in_q <= '0;
            io_pad_meta_q <= '0;
            io_pad_q <= '0;
        end else begin
            pad_in_meta_q <= pad_in_i;
            pad_in_q <= pad_in_meta_q;
            io_pad_meta_q <= io_pad_i;
            io_pad_q <= io_pad_meta_q;
        end
    end

    assign tck_rise = pins_q.tck & ~tck_prev_q;
    assign tck_fall = ~pins_q.tck & tck_prev_q;
    // the test reset is a pin, so it is only seen after the two stages
    assign tap_rst = rst_i | ~pins_q.trst_n;

    // ------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------
    jtg_tap_state_t state;

    jtg_tap_fsm u_fsm (
        .clk_i(clk_i),
        .rst_i(tap_rst),
        .tck_rise_i(tck_rise),
        .tms_i(pins_q.tms),
        .state_o(state)
    );

    logic in_cap_dr;
    logic in_shift_dr;
    logic in_upd_dr;
    logic in_cap_ir;
    logic in_shift_ir;
    logic in_upd_ir;

    assign in_cap_dr = (state == ST_CAP_DR);
    assign in_shift_dr = (state == ST_SHIFT_DR);
    assign in_upd_dr = (state == ST_UPD_DR);
    assign in_cap_ir = (state == ST_CAP_IR);
    assign in_shift_ir = (state == ST_SHIFT_IR);
    assign in_upd_ir = (state == ST_UPD_IR);

    // capture and shift act on the rising edge that leaves the state
    jtg_dr_ctl_t dr_ctl;
    assign dr_ctl = '{capture: tck_rise & in_cap_dr,
                      shift: tck_rise & in_shift_dr,
                      update: tck_fall & in_upd_dr};

    // ------------------------------------------------------------------
    // instruction register and decode
    // ------------------------------------------------------------------
    logic [IR_W-1:0] ir_shift_q;
    logic [IR_W-1:0] ir_q;
    jtg_dr_sel_t dr_sel;
    logic mode_extest;
    logic mode_intest;
    logic mode_stctest;

    always_ff @(posedge clk_i) begin
        if (tap_rst) begin
            ir_shift_q <= IR_CAPTURE_VAL;
        end else if (tck_rise && in_cap_ir) begin
            ir_shift_q <= IR_CAPTURE_VAL;
        end else if (tck_rise && in_shift_ir) begin
            ir_shift_q <= {pins_q.tdi, ir_shift_q[IR_W-1:1]};
        end
    end

    // new instruction lands on the falling edge inside update-ir
    always_ff @(posedge clk_i) begin
        if (tap_rst || state == ST_RESET) begin
            ir_q <= OP_IDCODE;
        end else if (tck_fall && in_upd_ir) begin
            ir_q <= ir_shift_q;
        end
    end

    always_comb begin
        dr_sel = SEL_BYPASS;
        mode_extest = 1'b0;
        mode_intest = 1'b0;
        mode_stctest = 1'b0;
        case (ir_q)
            OP_EXTEST: begin
                dr_sel = SEL_BSR;
                mode_extest = 1'b1;
            end
            OP_SAMPLE: begin
                dr_sel = SEL_BSR;
            end
            OP_IDCODE: begin
                dr_sel = SEL_ID;
            end
            OP_STCTEST: begin
                dr_sel = SEL_BSR;
                mode_stctest = 1'b1;
            end
            OP_INTEST: begin
                dr_sel = SEL_BSR;
                mode_intest = 1'b1;
            end
            default: begin
                dr_sel = SEL_BYPASS;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // bypass and identification registers
    // ------------------------------------------------------------------
    logic bypass_q;
    logic [ID_W-1:0] id_shift_q;

    always_ff @(posedge clk_i) begin
        if (tap_rst) begin
            bypass_q <= 1'b0;
        end else if (dr_sel == SEL_BYPASS && dr_ctl.capture) begin
            bypass_q <= 1'b0;
        end else if (dr_sel == SEL_BYPASS && dr_ctl.shift) begin
            bypass_q <= pins_q.tdi;
        end
    end

    always_ff @(posedge clk_i) begin
        if (tap_rst) begin
            id_shift_q <= ID_CODE;
        end else if (dr_sel == SEL_ID && dr_ctl.capture) begin
            id_shift_q <= ID_CODE;
        end else if (dr_sel == SEL_ID && dr_ctl.shift) begin
            id_shift_q <= {pins_q.tdi, id_shift_q[ID_W-1:1]};
        end
    end

    // ------------------------------------------------------------------
    // boundary-scan chain: per-cell capture source
    // ------------------------------------------------------------------
    logic [BSR_LEN-1:0] bsr_cap;
    logic [BSR_LEN-1:0] bsr_upd;
    logic bsr_serial;
    jtg_dr_ctl_t bsr_ctl;

    for (genvar i = 0; i < BSR_LEN; i++) begin : g_cell
        localparam jtg_cell_kind_t KIND = jtg_cell_kind(i);
        if (KIND == CK_IN && i >= ID_BASE) begin : g_in_id
            assign bsr_cap[i] = mode_stctest ? ID_CODE[i-ID_BASE]
                                             : pad_in_q[i-IN_BASE];
        end else if (KIND == CK_IN) begin : g_in
            assign bsr_cap[i] = pad_in_q[i-IN_BASE];
        end else if (KIND == CK_OUT) begin : g_out
            assign bsr_cap[i] = core_out_i[i-OUT_BASE];
        end else if (KIND == CK_IO) begin : g_io
            // internal test looks at the core, otherwise at the pad
            assign bsr_cap[i] = mode_intest ? core_io_out_i[i-IO_BASE]
                                            : io_pad_q[i-IO_BASE];
        end else if (KIND == CK_OEN) begin : g_oen
            assign bsr_cap[i] = core_io_oe_n_i;
        end else if (KIND == CK_LOGIC0) begin : g_zero
            assign bsr_cap[i] = 1'b0;
        end else if (KIND == CK_LOGIC1) begin : g_one
            assign bsr_cap[i] = 1'b1;
        end else begin : g_unconn
            // unbonded pad always drives, so its input is its own output
            assign bsr_cap[i] = bsr_upd[i];
        end
    end

    assign bsr_ctl = '{capture: dr_ctl.capture & (dr_sel == SEL_BSR),
                       shift: dr_ctl.shift & (dr_sel == SEL_BSR),
                       update: dr_ctl.update & (dr_sel == SEL_BSR)};

    jtg_bsr u_bsr (
        .clk_i(clk_i),
        .rst_i(tap_rst),
        .ctl_i(bsr_ctl),
        .tdi_i(pins_q.tdi),
        .cap_i(bsr_cap),
        .serial_o(bsr_serial),
        .upd_o(bsr_upd)
    );

    // ------------------------------------------------------------------
    // pad and core multiplexing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (tap_rst) begin
            out_pad_o <= '0;
            io_pad_o <= '0;
            io_pad_oe_n_o <= '1;
        end else if (mode_extest) begin
            out_pad_o <= bsr_upd[OUT_BASE +: NUM_OUT];
            io_pad_o <= bsr_upd[IO_BASE +: NUM_IO];
            io_pad_oe_n_o <= {NUM_IO{bsr_upd[OEN_CELL]}};
        end else begin
            out_pad_o <= core_out_i;
            io_pad_o <= core_io_out_i;
            io_pad_oe_n_o <= {NUM_IO{core_io_oe_n_i}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (tap_rst) begin
            core_in_o <= '0;
            core_io_in_o <= '0;
        end else if (mode_intest) begin
            core_in_o <= bsr_upd[IN_BASE +: NUM_IN];
            core_io_in_o <= bsr_upd[IO_BASE +: NUM_IO];
        end else begin
            core_in_o <= pad_in_q;
            core_io_in_o <= io_pad_q;
        end
    end

    // ------------------------------------------------------------------
    // serial output and scan clock
    // ------------------------------------------------------------------
    logic tdo_d;

    always_comb begin
        tdo_d = 1'b0;
        if (in_shift_ir) begin
            tdo_d = ir_shift_q[0];
        end else if (dr_sel == SEL_ID) begin
            tdo_d = id_shift_q[0];
        end else if (dr_sel == SEL_BSR) begin
            tdo_d = bsr_serial;
        end else begin
            tdo_d = bypass_q;
        end
    end

    // tdo moves half a test clock after the shift so the board samples
    // a settled value on its next rising edge
    always_ff @(posedge clk_i) begin
        if (tap_rst) begin
            tdo_o <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end else if (tck_fall) begin
            tdo_o <= tdo_d;
            tdo_oe_n_o <= ~(in_shift_dr | in_shift_ir);
        end
    end

    // the scan clock freezes at its last level outside capture and shift
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_reg_scan_clock_o <= 1'b0;
        end else if (in_cap_dr || in_shift_dr) begin
            data_reg_scan_clock_o <= pins_q.tck;
        end
    end

    assign tap_state_o = state;
    assign instr_o = ir_q;

endmodule

// ### test/jtg_board_model.sv
// board test equipment model driving the test access pins
`timescale 1ns/1ps
module jtg_board_model (
    // system clock used to pace the pins
    input wire logic clk_i,
    // test access pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    input wire logic tdo_i
);
    // half of the 160 ns test clock in 8 ns cycles
    localparam int HALF = 10;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
    end

    // one test clock; tdi toggles outside shifts so stale data never
    // passes for a real bit, and tck stands still between calls
    task automatic step(input logic m, input logic sh, input logic d,
                        output logic q);
        @(posedge clk_i);
        tck_o <= 1'b0;
        tms_o <= m;
        tdi_o <= sh ? d : ~tdi_o;
        repeat (HALF) @(posedge clk_i);
        q = tdo_i;
        tck_o <= 1'b1;
        repeat (HALF - 1) @(posedge clk_i);
    endtask

    task automatic test_reset(input int n);
        @(posedge clk_i);
        trst_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        trst_n_o <= 1'b1;
    endtask
endmodule

// ### test/jtg_tap_props.sv
// assertions on the test access port pins and status
`timescale 1ns/1ps
module jtg_tap_props
    import jtg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // test access pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic trst_n_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_n_o,
    input wire logic data_reg_scan_clock_o,
    // pads and status
    input wire logic [NUM_OUT-1:0] out_pad_o,
    input wire logic [NUM_IO-1:0] io_pad_oe_n_o,
    input wire logic core_io_oe_n_i,
    input jtg_tap_state_t tap_state_o,
    input wire logic [IR_W-1:0] instr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic tck_q;
    logic [2:0] high_cnt_q;

    // saturating count of tck rises seen with tms high
    always_ff @(posedge clk_i) begin
        tck_q <= tck_i;
        if (rst_i || !trst_n_i) begin
            high_cnt_q <= 3'h0;
        end else if (tck_i && !tck_q) begin
            if (!tms_i) begin
                high_cnt_q <= 3'h0;
            end else if (high_cnt_q != 3'h7) begin
                high_cnt_q <= high_cnt_q + 3'h1;
            end
        end
    end

    sequence trst_held;
        !trst_n_i [*3];
    endsequence

    sequence five_highs;
        $rose(high_cnt_q == 3'h5);
    endsequence

    oe_window_a: assert property (
        !tdo_oe_n_o |-> tap_state_o inside
        {ST_SHIFT_DR, ST_SHIFT_IR, ST_EXIT1_DR, ST_EXIT1_IR})
        else $error("tdo driven outside a shift");
    tdo_low_phase_a: assert property (
        $changed(tdo_o) |-> !tck_i)
        else $error("tdo changed while tck high");
    state_on_rise_a: assert property (
        $changed(tap_state_o) && tap_state_o != ST_RESET |-> tck_i)
        else $error("state moved without a tck rise");
    tms_graph_a: assert property (
        $changed(tap_state_o) && tap_state_o != ST_RESET |->
        (tap_state_o inside {ST_IDLE, ST_CAP_DR, ST_SHIFT_DR, ST_PAUSE_DR,
        ST_CAP_IR, ST_SHIFT_IR, ST_PAUSE_IR}) == !tms_i)
        else $error("state change disagrees with tms");
    five_high_a: assert property (
        five_highs |-> ##[0:8] tap_state_o == ST_RESET)
        else $error("five tms highs did not reach reset");
    reset_instr_a: assert property (
        tap_state_o == ST_RESET |-> ##2 instr_o == OP_IDCODE)
        else $error("reset state without identify instruction");
    trst_reset_a: assert property (
        trst_held |-> ##[0:2] tap_state_o == ST_RESET)
        else $error("test reset did not reset controller");
    scan_clk_a: assert property (
        $changed(data_reg_scan_clock_o) |->
        $past(tap_state_o, 3) inside {ST_CAP_DR, ST_SHIFT_DR} ||
        tap_state_o inside {ST_CAP_DR, ST_SHIFT_DR})
        else $error("scan clock moved outside capture or shift");
    pad_update_a: assert property (
        $changed(out_pad_o) && instr_o == OP_EXTEST && $stable(instr_o)
        |-> tap_state_o inside {ST_UPD_DR, ST_UPD_IR})
        else $error("output pads changed outside update");
    oen_shared_a: assert property (
        instr_o != OP_EXTEST |=>
        io_pad_oe_n_o == {NUM_IO{$past(core_io_oe_n_i)}})
        else $error("bidir enables not following core");
endmodule

bind jtg_tap_top jtg_tap_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i), .tms_i(tms_i),
    .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .data_reg_scan_clock_o(data_reg_scan_clock_o),
    .out_pad_o(out_pad_o), .io_pad_oe_n_o(io_pad_oe_n_o),
    .core_io_oe_n_i(core_io_oe_n_i),
    .tap_state_o(tap_state_o), .instr_o(instr_o)
);

// ### test/jtg_tap_top_tb_top.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
module jtg_tap_top_tb_top
    import jtg_pkg::*;
;
    // identification code, value arbitrary
    localparam logic [ID_W-1:0] ID_VAL = 32'h0000_2A53;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic tck, tms, tdi, trst_n, tdo_o, tdo_oe_n_o, scan_clk;
    logic [NUM_IN-1:0] pad_in_i, core_in_o;
    logic [NUM_OUT-1:0] out_pad_o, core_out_i;
    logic [NUM_IO-1:0] io_pad_i, io_pad_o, io_pad_oe_n_o;
    logic [NUM_IO-1:0] core_io_out_i, core_io_in_o;
    logic core_io_oe_n_i;
    jtg_tap_state_t tap_state_o;
    logic [IR_W-1:0] instr_o;
    logic [BSR_LEN-1:0] v;
    int mismatches = 0;
    int comparisons = 0;

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); \
        end \
    end

    always #4 clk_i = ~clk_i;

    jtg_tap_top #(.ID_CODE(ID_VAL)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo_o),
        .tdo_oe_n_o(tdo_oe_n_o), .data_reg_scan_clock_o(scan_clk),
        .pad_in_i(pad_in_i), .out_pad_o(out_pad_o), .io_pad_i(io_pad_i),
        .io_pad_o(io_pad_o), .io_pad_oe_n_o(io_pad_oe_n_o),
        .core_in_o(core_in_o), .core_out_i(core_out_i),
        .core_io_out_i(core_io_out_i), .core_io_oe_n_i(core_io_oe_n_i),
        .core_io_in_o(core_io_in_o), .tap_state_o(tap_state_o),
        .instr_o(instr_o)
    );

    jtg_board_model brd (
        .clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n), .tdo_i(tdo_o)
    );

    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic walk(input logic [7:0] ms, input int n);
        logic q;
        for (int i = 0; i < n; i++) brd.step(ms[i], 1'b0, 1'b0, q);
    endtask

    // from idle through shift-ir and update-ir back to idle, lsb first
    task automatic load_ir(input logic [IR_W-1:0] op);
        logic q;
        walk(8'h03, 4);
        for (int i = 0; i < IR_W; i++) brd.step(i == 2, 1'b1, op[i], q);
        walk(8'h01, 2);
    endtask

    task automatic scan_dr(input int n, input logic [BSR_LEN-1:0] din,
                           output logic [BSR_LEN-1:0] dout);
        logic q;
        dout = '0;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            brd.step(i == n - 1, 1'b1, din[i], q);
            dout[i] = q;
        end
        walk(8'h01, 2);
    endtask

    task automatic t_idcode();
        `CHK(tap_state_o, ST_RESET)
        `CHK(instr_o, OP_IDCODE)
        `CHK(tdo_oe_n_o, 1'b1)
        walk(8'h00, 1);
        scan_dr(ID_W, '0, v);
        `CHK(v[ID_W-1:0], ID_VAL)
    endtask

    task automatic t_bypass();
        logic [IR_W-1:0] ops [3] = '{3'h5, 3'h6, OP_BYPASS};
        foreach (ops[k]) begin
            load_ir(ops[k]);
            `CHK(instr_o, ops[k])
            scan_dr(9, 365'h0B5, v);
            `CHK(v[8:0], 9'h16A)
        end
    endtask

    task automatic t_sample();
        logic [BSR_LEN-1:0] exp;
        logic [NUM_IN-1:0] pin;
        pin = {1'b1, 76'h5_0F0F_3C3C_A5A5_1234};
        @(posedge clk_i);
        pad_in_i <= pin;
        load_ir(OP_SAMPLE);
        exp = '0;
        exp[IO_BASE-1:0] = core_out_i;
        exp[OEN_CELL-1:IO_BASE] = io_pad_i;
        exp[OEN_CELL] = core_io_oe_n_i;
        exp[LOGIC1_HI:LOGIC1_LO] = '1;
        scan_dr(BSR_LEN, '0, v);
        `CHK(v[LOGIC1_HI:0], exp[LOGIC1_HI:0])
        `CHK(v[BSR_LEN-1:IN_BASE], pin)
        `CHK(v[CELL_RX_FAST_LINK_DATA_CLOCK], 1'b1)
    endtask

    task automatic t_extest();
        logic [BSR_LEN-1:0] pat;
        load_ir(OP_EXTEST);
        pat = '0;
        pat[IO_BASE-1:0] = 8'hA6;
        pat[OEN_CELL-1:IO_BASE] = 8'h5B;
        pat[UNCONN_HI:UNCONN_LO] = 2'h2;
        scan_dr(BSR_LEN, pat, v);
        `CHK(out_pad_o, 8'hA6)
        `CHK(io_pad_o, 8'h5B)
        `CHK(io_pad_oe_n_o, 8'h00)
        pat[OEN_CELL] = 1'b1;
        scan_dr(BSR_LEN, pat, v);
        `CHK(io_pad_oe_n_o, 8'hFF)
        `CHK(v[UNCONN_HI:UNCONN_LO], 2'h2)
    endtask

    task automatic t_stctest_intest();
        load_ir(OP_STCTEST);
        scan_dr(BSR_LEN, '0, v);
        `CHK(v[BSR_LEN-1:ID_BASE], ID_VAL)
        load_ir(OP_INTEST);
        scan_dr(BSR_LEN, {77'h1357_9BDF, 272'h0, 8'hC3, 8'h0}, v);
        `CHK(core_in_o, 77'h1357_9BDF)
        `CHK(core_io_in_o, 8'hC3)
    endtask

    task automatic t_resets();
        load_ir(OP_BYPASS);
        walk(8'h01, 3);
        walk(8'h1F, 5);
        `CHK(tap_state_o, ST_RESET)
        `CHK(instr_o, OP_IDCODE)
        walk(8'h00, 1);
        load_ir(OP_EXTEST);
        brd.test_reset(4);
        repeat (4) @(posedge clk_i);
        `CHK(tap_state_o, ST_RESET)
        `CHK(instr_o, OP_IDCODE)
    endtask

    initial begin
        pad_in_i = '0;
        core_out_i = 8'h3C;
        io_pad_i = 8'h96;
        core_io_out_i = 8'h69;
        core_io_oe_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_stctest_intest();
        t_resets();
        tally_and_finish();
    end

    // whole run is near 40k cycles; cut a hang well beyond that
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule
